// ===== logic/sisr_defs.svh
// Function
// - live status bits are read-only and show conditions at read time
// - sticky bits stay set until host writes one to that bit
// - clearing a sticky bit fails and resets while its fault persists
// - sticky bit reaches interrupt pin only when its enable bit is one
// - interrupt stays low while any enabled sticky bit is set
// - input status bits read one when active, zero on signal loss
// - loop lock bits read one when locked; holdover bit one when not
// - selected input bit reads which input is reference, live only
// - automatic mode: reference bit low while lost or reselecting
// - manual modes: reference bit low while reference lost; auto holdover mode: low while lost with holdover bit zero
// - lock output high only when both sticky lock indications show locked
// - slave answers at address 11011 plus two select-pin bits
// - two low address bits come from the three-level select pin
// - slave runs at standard and fast bus clock rates
// - first written byte after address sets the register pointer
// - block transfers walk ascending addresses, bytes msb first
// - master may stop a block transfer after any complete byte
// - each written byte lands in its register when it completes
// - soft reset reloads defaults above address one, then clears itself
// - address register is read-only and shows the bus address
// - bus address after reset follows the strap pins; other defaults are fixed
// - status bits are valid only after power-up reset release
`ifndef SISR_DEFS_SVH
`define SISR_DEFS_SVH

`define SISR_REG_SOFT_RESET 8'h00
`define SISR_REG_BUS_ADDR 8'h01
`define SISR_REG_IO_VOLTAGE 8'h1F
`define SISR_REG_IRQ_ENABLE 8'h4C
`define SISR_REG_STICKY 8'h50
`define SISR_REG_LIVE 8'h51

`define SISR_BASE_ADDR 5'h1B
`define SISR_SOFT_RESET_BIT 0
`define SISR_IO_LEVEL_RESET 1'h1
`define SISR_IRQ_ENABLE_RESET 6'h00
`define SISR_STICKY_RESET 6'h00
`define SISR_STICKY_BITS 6
`define SISR_REF_BIT 5
`define SISR_LOOP1_BIT 2
`define SISR_LOOP2_BIT 3
`define SISR_VALID_DELAY 2'h3

`endif

// ===== logic/sisr_pkg.sv
`default_nettype none
package sisr_pkg;
    typedef struct packed {
        logic vco_cal_live;
        logic selected_input_live;
        logic ref_valid_live;
        logic no_holdover_live;
        logic loop2_locked_live;
        logic loop1_locked_live;
        logic in1_active_live;
        logic in0_active_live;
    } sisr_status_t;

    typedef struct packed {
        logic vco_cal;
        logic selected_input;
        logic ref_lost;
        logic reselecting;
        logic no_holdover;
        logic loop2_locked;
        logic loop1_locked;
        logic in1_active;
        logic in0_active;
    } sisr_cond_t;

    typedef enum logic [1:0] {
        SISR_MODE_AUTO = 2'h0,
        SISR_MODE_AUTO_HOLD = 2'h1,
        SISR_MODE_MANUAL = 2'h2,
        SISR_MODE_MANUAL_HOLD = 2'h3
    } sisr_mode_t;

    typedef enum logic [6:0] {
        SISR_IDLE = 7'h01,
        SISR_DEV = 7'h02,
        SISR_REG = 7'h04,
        SISR_WR = 7'h08,
        SISR_ACK = 7'h10,
        SISR_RD = 7'h20,
        SISR_MACK = 7'h40
    } sisr_state_t;
endpackage : sisr_pkg
`default_nettype wire

// ===== logic/sisr_top.sv
`include "sisr_defs.svh"
`default_nettype none
module sisr_top (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    input wire logic [1:0] addr_level_i,
    input wire sisr_pkg::sisr_cond_t cond_i,
    input wire logic [1:0] sel_mode_i,
    output logic irq_out_n_o,
    output logic lock_o,
    output logic io_level_select_o
);
    // two-flop synchronisers for every pin
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [1:0] lvl_meta;
    logic [1:0] lvl_sync;
    logic [1:0] mode_meta;
    logic [1:0] mode_sync;
    sisr_pkg::sisr_cond_t cond_meta;
    sisr_pkg::sisr_cond_t cond_sync;
    logic scl_prev;
    logic sda_prev;

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            lvl_meta <= 2'h0;
            lvl_sync <= 2'h0;
            mode_meta <= 2'h0;
            mode_sync <= 2'h0;
            cond_meta <= '0;
            cond_sync <= '0;
            scl_prev <= 1'h1;
            sda_prev <= 1'h1;
        end else begin
            scl_sync <= {scl_sync[0], scl_i};
            sda_sync <= {sda_sync[0], sda_i};
            lvl_meta <= addr_level_i;
            lvl_sync <= lvl_meta;
            mode_meta <= sel_mode_i;
            mode_sync <= mode_meta;
            cond_meta <= cond_i;
            cond_sync <= cond_meta;
            scl_prev <= scl_sync[1];
            sda_prev <= sda_sync[1];
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    assign scl_rise = scl_sync[1] && !scl_prev;
    assign scl_fall = !scl_sync[1] && scl_prev;
    assign bus_start = scl_sync[1] && scl_prev && sda_prev && !sda_sync[1];
    assign bus_stop = scl_sync[1] && scl_prev && !sda_prev && sda_sync[1];

    // strap capture and power-up valid delay
    logic [1:0] valid_cnt;
    logic status_valid;
    logic [1:0] addr_low;

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            valid_cnt <= 2'h0;
            addr_low <= 2'h0;
        end else if (valid_cnt != `SISR_VALID_DELAY) begin
            valid_cnt <= valid_cnt + 2'h1;
            addr_low <= lvl_sync;
        end
    end
    assign status_valid = (valid_cnt == `SISR_VALID_DELAY);

    logic [6:0] dev_addr;
    assign dev_addr = {`SISR_BASE_ADDR, addr_low};

    function automatic logic ref_valid_f(input logic [1:0] mode,
                                         input sisr_pkg::sisr_cond_t c);
        unique case (mode)
            sisr_pkg::SISR_MODE_AUTO:
                ref_valid_f = !c.ref_lost && !c.reselecting;
            sisr_pkg::SISR_MODE_AUTO_HOLD:
                ref_valid_f = !(c.ref_lost && !c.no_holdover);
            default:
                ref_valid_f = !c.ref_lost;
        endcase
    endfunction : ref_valid_f

    // live status, zero until valid
    sisr_pkg::sisr_status_t live;
    always_comb begin
        live = '0;
        if (status_valid) begin
            live.in0_active_live = cond_sync.in0_active;
            live.in1_active_live = cond_sync.in1_active;
            live.loop1_locked_live = cond_sync.loop1_locked;
            live.loop2_locked_live = cond_sync.loop2_locked;
            live.no_holdover_live = cond_sync.no_holdover;
            live.ref_valid_live = ref_valid_f(mode_sync, cond_sync);
            live.selected_input_live = cond_sync.selected_input;
            live.vco_cal_live = cond_sync.vco_cal;
        end
    end

    // register write strobe from the serial engine
    logic wr_stb;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [5:0] sticky;
    logic [5:0] irq_enable;
    logic soft_reset_bit;
    logic [5:0] fault;
    logic [5:0] clr;

    assign fault = status_valid ? ~live[5:0] : 6'h00;
    assign clr = (wr_stb && wr_addr == `SISR_REG_STICKY) ?
                 wr_data[5:0] : 6'h00;

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sticky <= `SISR_STICKY_RESET;
        end else if (soft_reset_bit) begin
            sticky <= `SISR_STICKY_RESET;
        end else begin
            sticky <= (sticky & ~clr) | fault;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_enable <= `SISR_IRQ_ENABLE_RESET;
            io_level_select_o <= `SISR_IO_LEVEL_RESET;
            soft_reset_bit <= 1'h0;
        end else begin
            soft_reset_bit <= wr_stb && wr_addr == `SISR_REG_SOFT_RESET &&
                              wr_data[`SISR_SOFT_RESET_BIT];
            if (soft_reset_bit) begin
                irq_enable <= `SISR_IRQ_ENABLE_RESET;
                io_level_select_o <= `SISR_IO_LEVEL_RESET;
            end else if (wr_stb) begin
                if (wr_addr == `SISR_REG_IRQ_ENABLE) begin
                    irq_enable <= wr_data[5:0];
                end
                if (wr_addr == `SISR_REG_IO_VOLTAGE) begin
                    io_level_select_o <= wr_data[0];
                end
            end
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_out_n_o <= 1'h1;
            lock_o <= 1'h0;
        end else begin
            irq_out_n_o <= !(|(sticky & irq_enable));
            lock_o <= status_valid && !sticky[`SISR_LOOP1_BIT] &&
                      !sticky[`SISR_LOOP2_BIT];
        end
    end

    function automatic logic [7:0] rd_byte(input logic [7:0] a);
        unique case (a)
            `SISR_REG_BUS_ADDR: rd_byte = {1'h0, dev_addr};
            `SISR_REG_IO_VOLTAGE: rd_byte = {7'h00, io_level_select_o};
            `SISR_REG_IRQ_ENABLE: rd_byte = {2'h0, irq_enable};
            `SISR_REG_STICKY: rd_byte = {2'h0, sticky};
            `SISR_REG_LIVE: rd_byte = live;
            default: rd_byte = 8'h00;
        endcase
    endfunction : rd_byte

    // byte at the pointer, loaded into the shifter at the start of each read byte
    logic [7:0] rd_cur;
    assign rd_cur = rd_byte(ptr);

    // serial slave engine
    sisr_pkg::sisr_state_t state;
    sisr_pkg::sisr_state_t after_ack;
    logic [7:0] shreg;
    logic [3:0] bitcnt;
    logic [7:0] ptr;
    logic read_dir;

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= sisr_pkg::SISR_IDLE;
            after_ack <= sisr_pkg::SISR_IDLE;
            shreg <= 8'h00;
            bitcnt <= 4'h0;
            ptr <= 8'h00;
            read_dir <= 1'h0;
            sda_o <= 1'h0;
            sda_oe_n_o <= 1'h1;
            wr_stb <= 1'h0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
        end else begin
            wr_stb <= 1'h0;
            if (bus_start) begin
                state <= sisr_pkg::SISR_DEV;
                bitcnt <= 4'h0;
                sda_oe_n_o <= 1'h1;
            end else if (bus_stop) begin
                state <= sisr_pkg::SISR_IDLE;
                sda_oe_n_o <= 1'h1;
            end else begin
                unique case (state)
                    sisr_pkg::SISR_IDLE: begin
                        sda_oe_n_o <= 1'h1;
                    end
                    sisr_pkg::SISR_DEV, sisr_pkg::SISR_REG,
                    sisr_pkg::SISR_WR: begin
                        if (scl_rise && bitcnt != 4'h8) begin
                            shreg <= {shreg[6:0], sda_sync[1]};
                            bitcnt <= bitcnt + 4'h1;
                        end else if (scl_fall && bitcnt == 4'h8) begin
                            bitcnt <= 4'h0;
                            if (state == sisr_pkg::SISR_DEV) begin
                                if (shreg[7:1] == dev_addr) begin
                                    read_dir <= shreg[0];
                                    after_ack <= shreg[0] ?
                                        sisr_pkg::SISR_RD :
                                        sisr_pkg::SISR_REG;
                                    state <= sisr_pkg::SISR_ACK;
                                    sda_oe_n_o <= 1'h0;
                                end else begin
                                    state <= sisr_pkg::SISR_IDLE;
                                end
                            end else if (state == sisr_pkg::SISR_REG) begin
                                ptr <= shreg;
                                after_ack <= sisr_pkg::SISR_WR;
                                state <= sisr_pkg::SISR_ACK;
                                sda_oe_n_o <= 1'h0;
                            end else begin
                                wr_stb <= 1'h1;
                                wr_addr <= ptr;
                                wr_data <= shreg;
                                ptr <= ptr + 8'h01;
                                after_ack <= sisr_pkg::SISR_WR;
                                state <= sisr_pkg::SISR_ACK;
                                sda_oe_n_o <= 1'h0;
                            end
                        end
                    end
                    sisr_pkg::SISR_ACK: begin
                        if (scl_fall) begin
                            state <= after_ack;
                            if (after_ack == sisr_pkg::SISR_RD) begin
                                shreg <= {rd_cur[6:0], 1'h0};
                                sda_oe_n_o <= rd_cur[7];
                                ptr <= ptr + 8'h01;
                                bitcnt <= 4'h1;
                            end else begin
                                sda_oe_n_o <= 1'h1;
                            end
                        end
                    end
                    sisr_pkg::SISR_RD: begin
                        if (scl_fall) begin
                            if (bitcnt == 4'h8) begin
                                state <= sisr_pkg::SISR_MACK;
                                sda_oe_n_o <= 1'h1;
                            end else begin
                                sda_oe_n_o <= shreg[7];
                                shreg <= {shreg[6:0], 1'h0};
                                bitcnt <= bitcnt + 4'h1;
                            end
                        end
                    end
                    sisr_pkg::SISR_MACK: begin
                        if (scl_rise && sda_sync[1]) begin
                            state <= sisr_pkg::SISR_IDLE;
                        end else if (scl_fall) begin
                            state <= sisr_pkg::SISR_RD;
                            shreg <= {rd_cur[6:0], 1'h0};
                            sda_oe_n_o <= rd_cur[7];
                            ptr <= ptr + 8'h01;
                            bitcnt <= 4'h1;
                        end
                    end
                endcase
            end
        end
    end

    // checks
    a_irq_follows_mask: assert property (@(posedge clock_i)
        disable iff (!arst_n_i)
        1 |=> irq_out_n_o == !(|($past(sticky) & $past(irq_enable))))
        else $error("irq pin disagrees with masked sticky bits");

    a_irq_held_low: assert property (@(posedge clock_i)
        disable iff (!arst_n_i)
        (|(sticky & irq_enable)) [*2] |-> !irq_out_n_o)
        else $error("irq released while enabled bit set");

    a_sticky_set_fault: assert property (@(posedge clock_i)
        disable iff (!arst_n_i)
        (fault[0] && !soft_reset_bit) |=> sticky[0])
        else $error("fault did not latch sticky bit");

    a_clear_fault_wins: assert property (@(posedge clock_i)
        disable iff (!arst_n_i)
        (clr[3] && fault[3] && !soft_reset_bit) |=> sticky[3])
        else $error("clear won over a persisting fault");

    a_sticky_holds: assert property (@(posedge clock_i)
        disable iff (!arst_n_i)
        (sticky[1] && !clr[1] && !soft_reset_bit) |=> sticky[1])
        else $error("sticky bit dropped without a clear");

    a_lock_pair: assert property (@(posedge clock_i)
        disable iff (!arst_n_i)
        (sticky[`SISR_LOOP1_BIT] || sticky[`SISR_LOOP2_BIT]) |=> !lock_o)
        else $error("lock high with a loop unlock latched");

    a_soft_reset_once: assert property (@(posedge clock_i)
        disable iff (!arst_n_i)
        soft_reset_bit |=> !soft_reset_bit ##0 irq_enable == 6'h00)
        else $error("soft reset did not clear itself");

    a_write_commit: assert property (@(posedge clock_i)
        disable iff (!arst_n_i)
        (wr_stb && wr_addr == `SISR_REG_IRQ_ENABLE) |=>
            irq_enable == $past(wr_data[5:0]) || $past(soft_reset_bit))
        else $error("written byte not committed at once");

    a_live_before_valid: assert property (@(posedge clock_i)
        disable iff (!arst_n_i)
        !status_valid |-> live == 8'h00 && sticky == 6'h00)
        else $error("status reported before power-up valid");

    a_ptr_ascends: assert property (@(posedge clock_i)
        disable iff (!arst_n_i)
        wr_stb |-> ptr == wr_addr + 8'h01)
        else $error("pointer did not step after a write");

    a_stop_to_idle: assert property (@(posedge clock_i)
        disable iff (!arst_n_i)
        bus_stop |=> state == sisr_pkg::SISR_IDLE)
        else $error("stop did not return the engine to idle");

    a_start_to_dev: assert property (@(posedge clock_i)
        disable iff (!arst_n_i)
        bus_start |=> (state == sisr_pkg::SISR_DEV && sda_oe_n_o))
        else $error("start did not reopen the address phase");

    a_idle_released: assert property (@(posedge clock_i)
        disable iff (!arst_n_i)
        (state == sisr_pkg::SISR_IDLE) |-> sda_oe_n_o)
        else $error("data line pulled low while idle");

    a_read_msb_first: assert property (@(posedge clock_i)
        disable iff (!arst_n_i)
        (state == sisr_pkg::SISR_ACK && after_ack == sisr_pkg::SISR_RD &&
         scl_fall && !bus_start && !bus_stop) |=>
            sda_oe_n_o == $past(rd_cur[7]))
        else $error("read byte did not begin with its top bit");

    c_irq_raised: cover property (@(posedge clock_i)
        disable iff (!arst_n_i) $fell(irq_out_n_o));
    c_block_write: cover property (@(posedge clock_i)
        disable iff (!arst_n_i) wr_stb ##[1:1000] wr_stb);
    c_read_byte: cover property (@(posedge clock_i)
        disable iff (!arst_n_i) state == sisr_pkg::SISR_MACK);
    c_soft_reset: cover property (@(posedge clock_i)
        disable iff (!arst_n_i) soft_reset_bit);
    c_block_read: cover property (@(posedge clock_i)
        disable iff (!arst_n_i)
        state == sisr_pkg::SISR_MACK ##1 state == sisr_pkg::SISR_RD);
endmodule : sisr_top
`default_nettype wire

// ===== verification/sisr_i2c_master.sv
`default_nettype none
module sisr_i2c_master (
    output var logic scl_o,
    output var logic sda_low_o,
    input wire logic sda_i
);
    timeunit 1ns;
    timeprecision 100ps;

    // quarter of the 80 ns bus clock period
    localparam int QTR = 20;

    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    // start or repeated start, leaves the clock low
    task start();
        #QTR sda_low_o = 1'b0;
        #QTR scl_o = 1'b1;
        #QTR sda_low_o = 1'b1;
        #QTR scl_o = 1'b0;
    endtask : start

    // stop may follow any complete byte
    task stop();
        #QTR sda_low_o = 1'b1;
        #QTR scl_o = 1'b1;
        #QTR sda_low_o = 1'b0;
        #QTR;
    endtask : stop

    // data changes only while the clock is low
    task bit_io(input logic b, output logic s);
        #QTR sda_low_o = ~b;
        #QTR scl_o = 1'b1;
        #QTR s = sda_i;
        #QTR scl_o = 1'b0;
    endtask : bit_io

    task write_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
        end
        bit_io(1'b1, s);
        ack = ~s;
    endtask : write_byte

    // master acks every byte but the last
    task read_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(last, s);
    endtask : read_byte
endmodule : sisr_i2c_master
`default_nettype wire

// ===== verification/sisr_top_tb.sv
`default_nettype none
module sisr_top_tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [6:0] DEV = {5'h1B, 2'h1};
    logic clock_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic scl, sda_low, sda_w, sda_o, sda_oe_n_o, irq_n, lock, io_lvl, ack;
    logic [1:0] mode = 2'h0;
    logic [1:0] lvl = 2'h1;
    logic [7:0] d;
    sisr_pkg::sisr_cond_t cond = 9'h01F;
    int fails = 0;
    int checks_done = 0;

    // open-drain bus with pull-up
    assign sda_w = ~(sda_low | (~sda_oe_n_o & ~sda_o));
    always #2.5 clock_i = ~clock_i;

    sisr_i2c_master i_master (.scl_o(scl), .sda_low_o(sda_low),
        .sda_i(sda_w));
    sisr_top i_dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .scl_i(scl),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
        .addr_level_i(lvl), .cond_i(cond), .sel_mode_i(mode),
        .irq_out_n_o(irq_n), .lock_o(lock), .io_level_select_o(io_lvl));

    task report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    task check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task settle();
        repeat (8) @(posedge clock_i);
        #1;
    endtask : settle

    task set_cond(input logic [8:0] v);
        @(posedge clock_i);
        #1 cond = v;
        settle();
    endtask : set_cond

    task begin_tx(input logic [7:0] ptr);
        i_master.start();
        i_master.write_byte({DEV, 1'b0}, ack);
        check(8'(ack), 8'h01);
        i_master.write_byte(ptr, ack);
    endtask : begin_tx

    task wr(input logic [7:0] ptr, input logic [7:0] v);
        begin_tx(ptr);
        i_master.write_byte(v, ack);
        i_master.stop();
    endtask : wr

    task rd(input logic [7:0] ptr, output logic [7:0] v);
        begin_tx(ptr);
        i_master.start();
        i_master.write_byte({DEV, 1'b1}, ack);
        i_master.read_byte(1'b1, v);
        i_master.stop();
    endtask : rd

    task rd_chk(input logic [7:0] ptr, input logic [7:0] exp);
        rd(ptr, d);
        check(d, exp);
    endtask : rd_chk

    function automatic logic [7:0] live_exp(input logic [1:0] m,
        input logic [8:0] c);
        logic rv;
        case (m)
            2'h0: rv = ~c[6] & ~c[5];
            2'h1: rv = ~(c[6] & ~c[4]);
            default: rv = ~c[6];
        endcase
        return {c[8], c[7], rv, c[4:0]};
    endfunction : live_exp

    task t_reset();
        rd_chk(8'h1F, 8'h01);
        rd_chk(8'h4C, 8'h00);
        rd_chk(8'h50, 8'h00);
        rd_chk(8'h01, {1'b0, DEV});
        check(8'(io_lvl), 8'h01);
        check(8'(irq_n), 8'h01);
        $display("reset test done");
    endtask : t_reset

    task t_addr();
        logic [7:0] bad [2];
        bad = '{8'hDE, 8'hD2};
        for (int i = 0; i < 2; i++) begin
            i_master.start();
            i_master.write_byte(bad[i], ack);
            i_master.stop();
            check(8'(ack), 8'h00);
        end
        wr(8'h01, 8'hFF);
        rd_chk(8'h01, {1'b0, DEV});
        $display("address test done");
    endtask : t_addr

    task t_live();
        logic [8:0] tab [5];
        tab = '{9'h01F, 9'h02F, 9'h04F, 9'h15A, 9'h0B5};
        for (int m = 0; m < 4; m++) begin
            for (int i = 0; i < 5; i++) begin
                @(posedge clock_i);
                #1 mode = 2'(m);
                set_cond(tab[i]);
                rd_chk(8'h51, live_exp(2'(m), tab[i]));
            end
        end
        mode = 2'h0;
        set_cond(9'h01F);
        wr(8'h50, 8'h3F);
        rd_chk(8'h50, 8'h00);
        $display("live status test done");
    endtask : t_live

    task t_sticky();
        wr(8'h4C, 8'h01);
        set_cond(9'h01D);
        check(8'(irq_n), 8'h01);
        rd_chk(8'h50, 8'h02);
        set_cond(9'h01C);
        check(8'(irq_n), 8'h00);
        wr(8'h50, 8'h01);
        rd_chk(8'h50, 8'h03);
        set_cond(9'h01F);
        check(8'(irq_n), 8'h00);
        rd_chk(8'h50, 8'h03);
        wr(8'h50, 8'h01);
        settle();
        check(8'(irq_n), 8'h01);
        rd_chk(8'h50, 8'h02);
        wr(8'h50, 8'h02);
        rd_chk(8'h50, 8'h00);
        $display("sticky test done");
    endtask : t_sticky

    task t_lock();
        for (int b = 2; b < 4; b++) begin
            set_cond(9'(9'h01F & ~(9'h001 << b)));
            set_cond(9'h01F);
            check(8'(lock), 8'h00);
            wr(8'h50, 8'(8'h01 << b));
            settle();
            check(8'(lock), 8'h01);
        end
        $display("lock test done");
    endtask : t_lock

    task t_block();
        begin_tx(8'h4C);
        i_master.write_byte(8'h15, ack);
        i_master.write_byte(8'hAA, ack);
        i_master.stop();
        rd_chk(8'h4C, 8'h15);
        rd_chk(8'h4D, 8'h00);
        begin_tx(8'h1F);
        i_master.write_byte(8'h00, ack);
        settle();
        check(8'(io_lvl), 8'h00);
        i_master.stop();
        begin_tx(8'h50);
        i_master.start();
        i_master.write_byte({DEV, 1'b1}, ack);
        i_master.read_byte(1'b0, d);
        check(d, 8'h00);
        i_master.read_byte(1'b1, d);
        check(d, 8'h3F);
        i_master.stop();
        $display("block test done");
    endtask : t_block

    task t_soft();
        wr(8'h4C, 8'h3F);
        set_cond(9'h01E);
        set_cond(9'h01F);
        check(8'(irq_n), 8'h00);
        wr(8'h00, 8'h01);
        settle();
        check(8'(io_lvl), 8'h01);
        check(8'(irq_n), 8'h01);
        rd_chk(8'h4C, 8'h00);
        rd_chk(8'h50, 8'h00);
        rd_chk(8'h00, 8'h00);
        rd_chk(8'h01, {1'b0, DEV});
        $display("soft reset test done");
    endtask : t_soft

    // mid-run reset with the select pin moved to its high level
    task t_strap();
        @(posedge clock_i);
        #1 arst_n_i = 1'b0;
        lvl = 2'h3;
        repeat (4) @(posedge clock_i);
        #1 arst_n_i = 1'b1;
        settle();
        check(8'(irq_n), 8'h01);
        check(8'(lock), 8'h01);
        check(8'(io_lvl), 8'h01);
        i_master.start();
        i_master.write_byte({DEV, 1'b0}, ack);
        i_master.stop();
        check(8'(ack), 8'h00);
        i_master.start();
        i_master.write_byte({5'h1B, 2'h3, 1'b0}, ack);
        check(8'(ack), 8'h01);
        i_master.write_byte(8'h01, ack);
        i_master.start();
        i_master.write_byte({5'h1B, 2'h3, 1'b1}, ack);
        i_master.read_byte(1'b1, d);
        i_master.stop();
        check(d, 8'h6F);
        $display("strap test done");
    endtask : t_strap

    initial begin
        repeat (16) @(posedge clock_i);
        #1 arst_n_i = 1'b1;
        repeat (8) @(posedge clock_i);
        #1;
        t_reset();
        t_addr();
        t_live();
        t_sticky();
        t_lock();
        t_block();
        t_soft();
        t_strap();
        report_and_stop();
    end

    // about two and a half times the expected run length
    initial begin
        #400000;
        fails++;
        report_and_stop();
    end
endmodule : sisr_top_tb
`default_nettype wire
